/* File: sac_pkg.sv */
package sac_pkg;

  // conversion and power-up timing, in converter clock cycles
  localparam int unsigned CONV_CYCLES  = 96;
  localparam int unsigned PWRUP_CYCLES = 4;
  localparam logic [6:0]  CONV_LAST    = 7'(CONV_CYCLES - 1);
  localparam logic [6:0]  PWRUP_LAST   = 7'(PWRUP_CYCLES - 1);

  // register byte offsets
  localparam logic [5:0] OFS_CS     = 6'h00;
  localparam logic [5:0] OFS_RESULT = 6'h04;
  localparam logic [5:0] OFS_FCS    = 6'h08;
  localparam logic [5:0] OFS_FIFO   = 6'h0c;
  localparam logic [5:0] OFS_DIV    = 6'h10;

  // control and status word
  localparam int unsigned CS_EN_BIT      = 0;
  localparam int unsigned CS_BIAS_BIT    = 1;
  localparam int unsigned CS_ONCE_BIT    = 2;
  localparam int unsigned CS_RUN_BIT     = 3;
  localparam int unsigned CS_READY_BIT   = 8;
  localparam int unsigned CS_ERR_BIT     = 9;
  localparam int unsigned CS_STICKY_BIT  = 10;
  localparam int unsigned CS_CHAN_LSB    = 12;
  localparam int unsigned CS_ROT_LSB     = 16;

  // fifo control and status word
  localparam int unsigned FCS_EN_BIT     = 0;
  localparam int unsigned FCS_NARROW_BIT = 1;
  localparam int unsigned FCS_TAG_BIT    = 2;
  localparam int unsigned FCS_DREQ_BIT   = 3;
  localparam int unsigned FCS_IRQEN_BIT  = 4;
  localparam int unsigned FCS_EMPTY_BIT  = 8;
  localparam int unsigned FCS_FULL_BIT   = 9;
  localparam int unsigned FCS_LOST_BIT   = 11;
  localparam int unsigned FCS_LEVEL_LSB  = 16;
  localparam int unsigned FIFO_TRIGGER_LEVEL_LSB = 24;

  // pacing divider word
  localparam int unsigned DIV_FRAC_LSB   = 0;
  localparam int unsigned DIV_WHOLE_LSB  = 8;

  localparam int unsigned FIFO_DEPTH     = 4;
  localparam logic [3:0]  THRESH_RESET   = 4'h0;

  typedef struct packed {
    logic        err;
    logic [11:0] value;
  } sac_sample_t;

  typedef struct packed {
    logic [15:0] whole;
    logic [7:0]  frac;
  } sac_pace_t;

  typedef enum {ST_OFF, ST_PWRUP, ST_IDLE, ST_CONV} sac_state_t;

endpackage

/* File: sac_pacer.sv */
`timescale 1ns/100ps
// fractional pacing timer: one tick per whole+1 cycles, stretched by one
// cycle whenever the fraction accumulator overflows
module sac_pacer (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire sac_pkg::sac_pace_t i_div,
  input  wire logic              i_restart,
  output logic                   o_tick
);

  logic [16:0] cnt_q;
  logic [7:0]  acc_q;
  logic [8:0]  sum;

  assign sum = {1'b0, acc_q} + {1'b0, i_div.frac};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= 17'h00000;
      acc_q  <= 8'h00;
      o_tick <= 1'b0;
    end else if (i_restart) begin
      cnt_q  <= {1'b0, i_div.whole};
      acc_q  <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt_q == 17'h00000) begin
      o_tick <= 1'b1;
      acc_q  <= sum[7:0];
      cnt_q  <= {1'b0, i_div.whole} + {16'h0000, sum[8]};
    end else begin
      o_tick <= 1'b0;
      cnt_q  <= cnt_q - 17'h00001;
    end
  end

endmodule

/* File: sac_fifo.sv */
`timescale 1ns/100ps
// four-entry sample store; a push into a full store is dropped
module sac_fifo (
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_push,
  input  wire sac_pkg::sac_sample_t i_data,
  input  wire logic                i_pop,
  output sac_pkg::sac_sample_t     o_data,
  output logic [2:0]               o_level,
  output logic                     o_full,
  output logic                     o_empty
);

  sac_pkg::sac_sample_t mem_q [sac_pkg::FIFO_DEPTH];
  logic [1:0] wr_q;
  logic [1:0] rd_q;
  logic       push_ok;
  logic       pop_ok;

  assign o_full  = (o_level == 3'h4);
  assign o_empty = (o_level == 3'h0);
  assign push_ok = i_push && !o_full;
  assign pop_ok  = i_pop && !o_empty;
  assign o_data  = mem_q[rd_q];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q    <= 2'h0;
      rd_q    <= 2'h0;
      o_level <= 3'h0;
      for (int i = 0; i < sac_pkg::FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (push_ok) begin
        mem_q[wr_q] <= i_data;
        wr_q        <= wr_q + 2'h1;
      end
      if (pop_ok) begin
        rd_q <= rd_q + 2'h1;
      end
      if (push_ok && !pop_ok) begin
        o_level <= o_level + 3'h1;
      end else if (pop_ok && !push_ok) begin
        o_level <= o_level - 3'h1;
      end
    end
  end

endmodule

/* File: sac_sequencer.sv */
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module sac_sequencer (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [11:0] i_sar_data,
  input  wire logic        i_sar_err,
  output logic             o_sar_power,
  output logic             o_sar_start,
  output logic [2:0]       o_sar_chan,
  output logic             o_temp_bias_on,
  output logic             o_fifo_irq,
  output logic             o_dreq
);

  sac_pkg::sac_state_t  state_q;
  logic [6:0]           cnt_q;

  // software controls
  logic                 en_q;
  logic                 run_q;
  logic [4:0]           rot_q;
  logic                 fifo_en_q;
  logic                 narrow_q;
  logic                 tag_q;
  logic                 dreq_en_q;
  logic                 irq_en_q;
  logic [3:0]           thresh_q;
  sac_pkg::sac_pace_t   div_q;

  // block state
  logic [11:0]          result_q;
  logic                 err_q;
  logic                 sticky_q;
  logic                 lost_q;

  // bus
  logic                 req;
  logic                 accept;
  logic                 wr_fire;
  logic [5:0]           word_addr;
  logic [31:0]          be_mask;
  logic [31:0]          merged;
  logic [31:0]          wclr;
  logic                 wr_cs;
  logic                 wr_fcs;
  logic                 wr_div;

  // conversion events
  logic                 pace_zero;
  logic                 tick;
  logic                 start_once;
  logic                 start_req;
  logic                 done;
  logic                 restart;

  // fifo
  sac_pkg::sac_sample_t push_data;
  sac_pkg::sac_sample_t head;
  logic [2:0]           level;
  logic                 full;
  logic                 empty;
  logic                 pop;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // next channel after cur whose mask bit is set; cur if none
  function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [4:0] mask);
    logic [2:0] c;
    logic       found;
    c         = cur;
    found     = 1'b0;
    next_chan = cur;
    for (int i = 0; i < 5; i++) begin
      c = (c >= 3'h4) ? 3'h0 : c + 3'h1;
      if (!found && mask[c]) begin
        next_chan = c;
        found     = 1'b1;
      end
    end
  endfunction

  function automatic logic [31:0] reg_read(input logic [5:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      sac_pkg::OFS_CS: begin
        w[sac_pkg::CS_EN_BIT]     = en_q;
        w[sac_pkg::CS_BIAS_BIT]   = o_temp_bias_on;
        w[sac_pkg::CS_RUN_BIT]    = run_q;
        w[sac_pkg::CS_READY_BIT]  = (state_q == sac_pkg::ST_IDLE);
        w[sac_pkg::CS_ERR_BIT]    = err_q;
        w[sac_pkg::CS_STICKY_BIT] = sticky_q;
        w[sac_pkg::CS_CHAN_LSB +: 3] = o_sar_chan;
        w[sac_pkg::CS_ROT_LSB +: 5]  = rot_q;
      end
      sac_pkg::OFS_RESULT: w[11:0] = result_q;
      sac_pkg::OFS_FCS: begin
        w[sac_pkg::FCS_EN_BIT]     = fifo_en_q;
        w[sac_pkg::FCS_NARROW_BIT] = narrow_q;
        w[sac_pkg::FCS_TAG_BIT]    = tag_q;
        w[sac_pkg::FCS_DREQ_BIT]   = dreq_en_q;
        w[sac_pkg::FCS_IRQEN_BIT]  = irq_en_q;
        w[sac_pkg::FCS_EMPTY_BIT]  = empty;
        w[sac_pkg::FCS_FULL_BIT]   = full;
        w[sac_pkg::FCS_LOST_BIT]   = lost_q;
        w[sac_pkg::FCS_LEVEL_LSB +: 3]  = level;
        w[sac_pkg::FIFO_TRIGGER_LEVEL_LSB +: 4] = thresh_q;
      end
      sac_pkg::OFS_FIFO: w[12:0] = head;
      sac_pkg::OFS_DIV: begin
        w[sac_pkg::DIV_FRAC_LSB +: 8]   = div_q.frac;
        w[sac_pkg::DIV_WHOLE_LSB +: 16] = div_q.whole;
      end
      default: w = 32'h00000000;
    endcase
    reg_read = w;
  endfunction

  // bus: request seen with waitrequest high, answered the next cycle
  assign req       = i_avs_read || i_avs_write;
  assign accept    = req && o_avs_waitrequest;
  assign wr_fire   = i_avs_write && !o_avs_waitrequest;
  assign word_addr = {i_avs_address[5:2], 2'b00};
  assign be_mask   = lane_mask(i_avs_byteenable);
  // reg_read looks at block state, so only always_comb re-evaluates on its changes
  always_comb merged = (reg_read(word_addr) & ~be_mask) | (i_avs_writedata & be_mask);
  assign wclr      = i_avs_writedata & be_mask;
  assign wr_cs     = wr_fire && (word_addr == sac_pkg::OFS_CS);
  assign wr_fcs    = wr_fire && (word_addr == sac_pkg::OFS_FCS);
  assign wr_div    = wr_fire && (word_addr == sac_pkg::OFS_DIV);
  // pop at acceptance so the read word and the pointer move together
  assign pop       = accept && i_avs_read && (word_addr == sac_pkg::OFS_FIFO);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= !accept;
      o_avs_readdata    <= (accept && i_avs_read) ? reg_read(word_addr) : 32'h00000000;
    end
  end

  // conversion events
  assign pace_zero  = (div_q.whole == 16'h0000);
  assign start_once = wr_cs && merged[sac_pkg::CS_ONCE_BIT];
  assign done       = (state_q == sac_pkg::ST_CONV) && (cnt_q == sac_pkg::CONV_LAST);
  assign restart    = done && run_q && pace_zero && en_q;
  // a tick landing outside idle is simply lost
  assign start_req  = (state_q == sac_pkg::ST_IDLE) && en_q &&
                      (start_once || (run_q && (pace_zero || tick)));

  sac_pacer u_pacer (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_div     (div_q),
    .i_restart (!run_q || wr_div || pace_zero),
    .o_tick    (tick)
  );

  // sequencer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= sac_pkg::ST_OFF;
      cnt_q   <= 7'h00;
    end else if (!en_q) begin
      state_q <= sac_pkg::ST_OFF;
      cnt_q   <= 7'h00;
    end else begin
      case (state_q)
        sac_pkg::ST_OFF: begin
          state_q <= sac_pkg::ST_PWRUP;
          cnt_q   <= 7'h00;
        end
        sac_pkg::ST_PWRUP: begin
          if (cnt_q == sac_pkg::PWRUP_LAST) begin
            state_q <= sac_pkg::ST_IDLE;
            cnt_q   <= 7'h00;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        sac_pkg::ST_IDLE: begin
          if (start_req) begin
            state_q <= sac_pkg::ST_CONV;
            cnt_q   <= 7'h00;
          end
        end
        sac_pkg::ST_CONV: begin
          if (done) begin
            // run cleared mid-conversion lands here and goes idle
            state_q <= restart ? sac_pkg::ST_CONV : sac_pkg::ST_IDLE;
            cnt_q   <= 7'h00;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        default: begin
          state_q <= sac_pkg::ST_OFF;
          cnt_q   <= 7'h00;
        end
      endcase
    end
  end

  // analogue-side drive
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sar_power <= 1'b0;
      o_sar_start <= 1'b0;
    end else begin
      o_sar_power <= en_q;
      o_sar_start <= start_req || restart;
    end
  end

  // control and status word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q           <= 1'b0;
      o_temp_bias_on <= 1'b0;
      run_q          <= 1'b0;
      rot_q          <= 5'h00;
    end else if (wr_cs) begin
      en_q           <= merged[sac_pkg::CS_EN_BIT];
      o_temp_bias_on <= merged[sac_pkg::CS_BIAS_BIT];
      run_q          <= merged[sac_pkg::CS_RUN_BIT];
      rot_q          <= merged[sac_pkg::CS_ROT_LSB +: 5];
    end
  end

  // channel select; a software write beats an automatic advance
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sar_chan <= 3'h0;
    end else if (wr_cs) begin
      o_sar_chan <= merged[sac_pkg::CS_CHAN_LSB +: 3];
    end else if (done && run_q && (rot_q != 5'h00)) begin
      o_sar_chan <= next_chan(o_sar_chan, rot_q);
    end
  end

  // result and error flags
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_q <= 12'h000;
      err_q    <= 1'b0;
      sticky_q <= 1'b0;
    end else begin
      if (done) begin
        result_q <= i_sar_data;
        err_q    <= i_sar_err;
      end
      if (done && i_sar_err) begin
        sticky_q <= 1'b1;
      end else if (wr_cs && wclr[sac_pkg::CS_STICKY_BIT]) begin
        sticky_q <= 1'b0;
      end
    end
  end

  // fifo control
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fifo_en_q <= 1'b0;
      narrow_q  <= 1'b0;
      tag_q     <= 1'b0;
      dreq_en_q <= 1'b0;
      irq_en_q  <= 1'b0;
      thresh_q  <= sac_pkg::THRESH_RESET;
    end else if (wr_fcs) begin
      fifo_en_q <= merged[sac_pkg::FCS_EN_BIT];
      narrow_q  <= merged[sac_pkg::FCS_NARROW_BIT];
      tag_q     <= merged[sac_pkg::FCS_TAG_BIT];
      dreq_en_q <= merged[sac_pkg::FCS_DREQ_BIT];
      irq_en_q  <= merged[sac_pkg::FCS_IRQEN_BIT];
      thresh_q  <= merged[sac_pkg::FIFO_TRIGGER_LEVEL_LSB +: 4];
    end
  end

  // lost-sample flag: a new loss wins over a same-cycle clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lost_q <= 1'b0;
    end else if (done && fifo_en_q && full) begin
      lost_q <= 1'b1;
    end else if (wr_fcs && wclr[sac_pkg::FCS_LOST_BIT]) begin
      lost_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= '0;
    end else if (wr_div) begin
      div_q.frac  <= merged[sac_pkg::DIV_FRAC_LSB +: 8];
      div_q.whole <= merged[sac_pkg::DIV_WHOLE_LSB +: 16];
    end
  end

  // narrowing trades precision for byte-wide transfers
  always_comb begin
    push_data.err   = tag_q && i_sar_err;
    push_data.value = narrow_q ? {4'h0, i_sar_data[11:4]} : i_sar_data;
  end

  sac_fifo u_fifo (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_push   (done && fifo_en_q),
    .i_data   (push_data),
    .i_pop    (pop),
    .o_data   (head),
    .o_level  (level),
    .o_full   (full),
    .o_empty  (empty)
  );

  // level-based requests fall once the fifo drains below the trigger
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fifo_irq <= 1'b0;
      o_dreq     <= 1'b0;
    end else begin
      o_fifo_irq <= irq_en_q && ({1'b0, level} >= thresh_q);
      o_dreq     <= dreq_en_q && ({1'b0, level} >= thresh_q);
    end
  end

endmodule

/* File: sac_sar_model.sv */
`timescale 1ns/100ps
// behavioural comparator array; the code depends only on the channel latched at start
module sac_sar_model (
  input  wire logic       i_clk,
  input  wire logic       i_power,
  input  wire logic       i_start,
  input  wire logic [2:0] i_chan,
  output logic [11:0]     o_data,
  output logic            o_err
);
  logic [6:0]  left_q;
  logic [2:0]  chan_q;
  logic [11:0] junk_q;
  logic        live;
  initial begin
    left_q = 7'h00;
    chan_q = 3'h0;
    junk_q = 12'h000;
  end
  always @(posedge i_clk) begin
    junk_q <= ~junk_q ^ 12'h0f3;
    if (i_start) begin
      left_q <= 7'h5f;
      chan_q <= i_chan;
    end else if (left_q != 7'h00) begin
      left_q <= left_q - 7'h01;
    end
  end
  // outside the conversion window the data lines alternate between 000 and f0c, so stale codes never pass
  assign live   = i_power && (left_q != 7'h00);
  assign o_data = live ? {chan_q, 1'b0, 8'h5a} : junk_q;
  assign o_err  = live ? (chan_q == 3'h3) : junk_q[0];
endmodule

/* File: sac_checker.sv */
`timescale 1ns/100ps
module sac_checker (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [11:0] i_sar_data,
  input wire logic        i_sar_err,
  input wire logic        o_sar_power,
  input wire logic        o_sar_start,
  input wire logic [2:0]  o_sar_chan,
  input wire logic        o_temp_bias_on,
  input wire logic        o_fifo_irq,
  input wire logic        o_dreq
);
  logic [6:0] gap_q;
  logic       cs_wr;
  assign cs_wr = i_avs_write && !o_avs_waitrequest && (i_avs_address[5:2] == 4'h0)
                 && i_avs_byteenable[0];
  // saturating count of cycles since the last start pulse
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) gap_q <= 7'h7f;
    else if (o_sar_start) gap_q <= 7'h00;
    else if (gap_q != 7'h7f) gap_q <= gap_q + 7'h01;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  conv_spacing_a: assert property (o_sar_start |-> gap_q >= 7'h5f)
    else $error("conversion started before the previous one ended");
  start_powered_a: assert property (o_sar_start |-> o_sar_power)
    else $error("conversion started while unpowered");
  powerup_hold_a: assert property ($rose(o_sar_power) |-> !o_sar_start [*4])
    else $error("conversion started during power-up");
  disable_off_a: assert property (cs_wr && !i_avs_writedata[0] |-> ##2 !o_sar_power)
    else $error("power stayed on after disable");
  bias_apart_a: assert property (cs_wr && !i_avs_writedata[1] |-> ##2 !o_temp_bias_on)
    else $error("bias on without its own bit");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
                                 |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  idle_data_a: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
    else $error("read data outside answer cycle");
  unmapped_zero_a: assert property (i_avs_read && o_avs_waitrequest
                                    && i_avs_address[5:2] > 4'h4 |=> o_avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  cover property (o_sar_start);
  cover property ($rose(o_sar_power));
  cover property (o_fifo_irq && o_dreq);
endmodule
bind sac_sequencer sac_checker u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_sar_data(i_sar_data), .i_sar_err(i_sar_err),
  .o_sar_power(o_sar_power), .o_sar_start(o_sar_start), .o_sar_chan(o_sar_chan),
  .o_temp_bias_on(o_temp_bias_on), .o_fifo_irq(o_fifo_irq), .o_dreq(o_dreq)
);

/* File: sac_sequencer_bench.sv */
`timescale 1ns/100ps
module sac_sequencer_bench;
  typedef struct packed {logic [2:0] chan; logic bias; logic [11:0] res;} sac_row_t;
  typedef struct packed {logic [15:0] whole; logic [7:0] frac; logic [9:0] sum;} sac_pace_t;
  logic        i_clk, i_resetn, i_avs_read, i_avs_write, i_sar_err;
  logic        o_avs_waitrequest, o_sar_power, o_sar_start, o_temp_bias_on;
  logic        o_fifo_irq, o_dreq;
  logic [2:0]  o_sar_chan;
  logic [3:0]  i_avs_byteenable;
  logic [5:0]  i_avs_address;
  logic [11:0] i_sar_data;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  int          miscompares, checks, n, m;
  sac_row_t    rows [5];
  sac_pace_t   pace [4];
  sac_sequencer uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_sar_data(i_sar_data), .i_sar_err(i_sar_err),
    .o_sar_power(o_sar_power), .o_sar_start(o_sar_start), .o_sar_chan(o_sar_chan),
    .o_temp_bias_on(o_temp_bias_on), .o_fifo_irq(o_fifo_irq), .o_dreq(o_dreq));
  sac_sar_model u_sar (.i_clk(i_clk), .i_power(o_sar_power), .i_start(o_sar_start),
    .i_chan(o_sar_chan), .o_data(i_sar_data), .o_err(i_sar_err));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task timeout;
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    results;
  endtask
  // holds the request until waitrequest is sampled low, then releases
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    if (wr) i_avs_write <= 1'b1;
    else i_avs_read <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) timeout;
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task wait_start(output int c);
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (o_sar_start !== 1'b1 && c < 400);
    if (c >= 400) timeout;
  endtask
  task wait_ready;
    int k;
    k = 0;
    do begin
      rd(sac_pkg::OFS_CS);
      k++;
    end while (q[8] !== 1'b1 && k < 200);
    if (k >= 200) timeout;
  endtask
  initial begin
    rows = '{'{3'h0, 1'b0, 12'h05a}, '{3'h1, 1'b1, 12'h25a}, '{3'h2, 1'b0, 12'h45a},
             '{3'h3, 1'b1, 12'h65a}, '{3'h4, 1'b1, 12'h85a}};
    pace = '{'{16'h0000, 8'h00, 10'h0c0}, '{16'h0032, 8'h00, 10'h0cc},
             '{16'h0064, 8'h80, 10'h0cb}, '{16'h0100, 8'h00, 10'h202}};
    {i_resetn, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
    i_avs_byteenable = 4'hf;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    chk({o_avs_waitrequest, o_sar_power, o_sar_start, o_temp_bias_on, o_dreq}, 5'h10);
    rd(sac_pkg::OFS_CS);
    chk(q, 32'h0);
    rd(sac_pkg::OFS_FCS);
    chk(q, 32'h100);
    wr(6'h14, 32'hffffffff);
    rd(6'h14);
    chk(q, 32'h0);
    wr(sac_pkg::OFS_CS, 32'h1);
    wait_ready;
    chk(o_sar_power, 1'b1);
    foreach (rows[i]) begin
      wr(sac_pkg::OFS_CS, {17'h0, rows[i].chan, 10'h0, rows[i].bias, 1'b1});
      wr(sac_pkg::OFS_CS, {17'h0, rows[i].chan, 10'h0, rows[i].bias, 1'b1} | 32'h4);
      wait_start(n);
      chk(o_sar_chan, rows[i].chan);
      chk(o_temp_bias_on, rows[i].bias);
      repeat (93) @(posedge i_clk);
      rd(sac_pkg::OFS_CS);
      chk(q[8], 1'b0);
      rd(sac_pkg::OFS_CS);
      chk(q[9:8], {rows[i].chan == 3'h3, 1'b1});
      rd(sac_pkg::OFS_RESULT);
      chk(q, rows[i].res);
    end
    foreach (pace[i]) begin
      wr(sac_pkg::OFS_DIV, {8'h00, pace[i].whole, pace[i].frac});
      wr(sac_pkg::OFS_CS, 32'h9);
      repeat (3) wait_start(n);
      wait_start(m);
      chk(n + m, pace[i].sum);
      wr(sac_pkg::OFS_CS, 32'h1);
      wait_ready;
    end
    wr(sac_pkg::OFS_CS, 32'h0006_0005);
    wait_ready;
    chk(o_sar_chan, 3'h0);
    wr(sac_pkg::OFS_DIV, 32'h0);
    wr(sac_pkg::OFS_FCS, 32'h1);
    wr(sac_pkg::OFS_CS, 32'h0006_0009);
    repeat (5) wait_start(n);
    chk(n, 96);
    wr(sac_pkg::OFS_CS, 32'h0006_0001);
    wait_ready;
    rd(sac_pkg::OFS_FCS);
    chk(q, 32'h0004_0a01);
    rd(sac_pkg::OFS_RESULT);
    chk(q, 32'h45a);
    for (int k = 0; k < 4; k++) begin
      rd(sac_pkg::OFS_FIFO);
      chk(q, rows[k == 3 ? 1 : k].res);
    end
    rd(sac_pkg::OFS_FCS);
    chk(q, 32'h901);
    wr(sac_pkg::OFS_FCS, 32'h801);
    rd(sac_pkg::OFS_FCS);
    chk(q, 32'h101);
    wr(sac_pkg::OFS_FCS, 32'h0200_001f);
    for (int k = 0; k < 2; k++) begin
      wr(sac_pkg::OFS_CS, 32'h3005);
      wait_ready;
      chk({o_fifo_irq, o_dreq}, {2{k == 1}});
    end
    for (int k = 0; k < 2; k++) begin
      rd(sac_pkg::OFS_FIFO);
      chk(q, 32'h1065);
      repeat (2) @(posedge i_clk);
      chk(o_fifo_irq, 1'b0);
    end
    wr(sac_pkg::OFS_CS, 32'h5);
    wait_start(n);
    wr(sac_pkg::OFS_CS, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(o_sar_power, 1'b0);
    wr(sac_pkg::OFS_CS, 32'h4);
    repeat (150) begin
      @(posedge i_clk);
      chk(o_sar_start, 1'b0);
    end
    wr(sac_pkg::OFS_CS, 32'h9);
    wait_start(n);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk({o_avs_waitrequest, o_sar_power, o_sar_start}, 3'h4);
    i_resetn <= 1'b1;
    rd(sac_pkg::OFS_CS);
    chk(q, 32'h0);
    results;
  end
endmodule
